// ### temp_alert.sv
/*
 * limit comparison, alert status, alert and critical open-drain outputs,
 * remote reading correction and standby gating of a remote diode sensor.
 * assumes conversion results arrive as a one-cycle strobe from the converter
 * and that host register accesses arrive as one-cycle pulses, all on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - compare readings to limits, set flags
// - unmasked alert flags pull alert low
// - alert and critical pins open-drain, active low
// - critical pin asserts above critical limit
// - critical and fan hysteresis held separately
// - format select chooses signed or unsigned
// - comparator mode releases alert when condition ends
// - comparator mode bit, reset zero
// - interrupt mode when comparator bit low
// - status read sets mask in interrupt mode while an alert-capable flag is set
// - status read clears flags, releases alert in interrupt mode
// - flags clear on read, reassert next conversion
// - standby stops continuous conversions
// - standby bit may stop fan output
// - local 8-bit, remote 11-bit left justified
// - filter widens remote to 13 bits
// - signed offset added to remote reading
// - critical clears at limit minus hysteresis
// - critical limit locked until unlock bit
module temp_alert (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// conversion results
	input  wire logic        conv_done,
	input  wire logic [7:0]  local_reading,
	input  wire logic [15:0] remote_raw,
	input  wire logic        conv_busy,
	input  wire logic        remote_diode_fault_flag,
	// limits and corrections
	input  wire logic [7:0]  local_high_limit,
	input  wire logic [15:0] remote_high_limit,
	input  wire logic [15:0] remote_low_limit,
	input  wire logic [7:0]  remote_offset_hi_byte,
	input  wire logic [7:0]  remote_offset_lo_byte,
	// critical limit and hysteresis writes
	input  wire logic        crit_limit_unlock,
	input  wire logic        crit_limit_wr,
	input  wire logic [15:0] crit_limit_wdata,
	input  wire logic        crit_hyst_wr,
	input  wire logic        lut_hyst_wr,
	input  wire logic [7:0]  hyst_wdata,
	// configuration
	input  wire logic        unsigned_format_sel,
	input  wire logic        filter_en,
	input  wire logic        comparator_mode,
	input  wire logic        standby,
	input  wire logic        pwm_off_in_standby,
	// host access
	input  wire logic        status_rd,
	input  wire logic        mask_wr,
	input  wire logic        mask_wdata,
	// status and corrected readings
	output logic [7:0]       status_q,
	output logic             alert_mask_q,
	output logic [15:0]      remote_reading_q,
	output logic [7:0]       local_reading_q,
	output logic [15:0]      crit_limit_q,
	output logic [7:0]       crit_hyst_q,
	output logic [7:0]       lut_hyst_q,
	// converter and fan control
	output logic             conv_run_q,
	output logic             pwm_run_q,
	// open-drain pins, enable low while pulling low
	output logic             alert_o,
	output logic             alert_oe_n_q,
	output logic             crit_temp_out_o,
	output logic             crit_temp_out_oe_n_q
);

	// ****************************************************************
	// reading correction
	// ****************************************************************
	logic signed [17:0] raw_x;      // raw reading extended
	logic signed [17:0] off_x;      // offset extended
	logic signed [17:0] sum_x;      // corrected, unclamped
	logic signed [17:0] hi_x;       // clamp top for format
	logic signed [17:0] lo_x;       // clamp bottom for format
	logic [15:0]        clamp_w;    // clamped reading
	logic [15:0]        res_mask;   // resolution mask
	logic               accept;     // result taken this cycle
	logic               cmp_ok_q;   // registered result ready to compare

	// results arriving during standby are dropped
	assign accept   = conv_done & ~standby;
	assign raw_x    = unsigned_format_sel ? $signed({2'b00, remote_raw})
	                                      : $signed({{2{remote_raw[15]}}, remote_raw});
	assign off_x    = $signed({{2{remote_offset_hi_byte[7]}},
	                           remote_offset_hi_byte, remote_offset_lo_byte});
	assign sum_x    = raw_x + off_x;
	assign hi_x     = unsigned_format_sel ? temp_alert_pkg::UNSIGNED_MAX
	                                      : temp_alert_pkg::SIGNED_MAX;
	assign lo_x     = unsigned_format_sel ? temp_alert_pkg::UNSIGNED_MIN
	                                      : temp_alert_pkg::SIGNED_MIN;
	// clamp instead of rolling over at full scale
	assign clamp_w  = (sum_x > hi_x) ? hi_x[15:0] : (sum_x < lo_x) ? lo_x[15:0] : sum_x[15:0];
	// 11-bit left justified, or 13-bit with the filter
	assign res_mask = filter_en ? temp_alert_pkg::RES_MASK_13
	                            : temp_alert_pkg::RES_MASK_11;

	// register the corrected results, stage one
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			remote_reading_q <= 16'h0000;
			local_reading_q  <= 8'h00;
			cmp_ok_q         <= 1'b0;
		end else begin
			cmp_ok_q <= accept;
			if (accept) begin
				remote_reading_q <= clamp_w & res_mask;
				local_reading_q  <= local_reading;
			end
		end
	end

	// ****************************************************************
	// limit comparators
	// ****************************************************************
	limit_cmp_if c_high ();   // remote high
	limit_cmp_if c_low ();    // remote low
	limit_cmp_if c_crit ();   // remote critical

	logic signed [16:0] rdg_x;  // reading in comparison format

	// one format select governs reading and all remote limits
	assign rdg_x          = unsigned_format_sel ? $signed({1'b0, remote_reading_q})
	                        : $signed({remote_reading_q[15], remote_reading_q});
	assign c_high.reading = rdg_x;
	assign c_low.reading  = rdg_x;
	assign c_crit.reading = rdg_x;
	assign c_high.limit   = unsigned_format_sel ? $signed({1'b0, remote_high_limit})
	                        : $signed({remote_high_limit[15], remote_high_limit});
	assign c_low.limit    = unsigned_format_sel ? $signed({1'b0, remote_low_limit})
	                        : $signed({remote_low_limit[15], remote_low_limit});
	assign c_crit.limit   = unsigned_format_sel ? $signed({1'b0, crit_limit_q})
	                        : $signed({crit_limit_q[15], crit_limit_q});

	limit_cmp u_high (.c(c_high));
	limit_cmp u_low  (.c(c_low));
	limit_cmp u_crit (.c(c_crit));

	// ****************************************************************
	// critical hysteresis at whole-degree resolution
	// ****************************************************************
	logic signed [9:0] rdg_int;     // reading, whole degrees
	logic signed [9:0] crit_rel;    // release threshold
	logic              local_hi;    // local above its limit
	logic              crit_q;      // critical condition with hysteresis
	logic              crit_d;

	assign rdg_int  = {rdg_x[16], rdg_x[16:8]};
	assign crit_rel = {c_crit.limit[16], c_crit.limit[16:8]} - $signed({2'b00, crit_hyst_q});
	assign local_hi = $signed(local_reading_q) > $signed(local_high_limit);
	// set above the limit, release only at or below limit minus hysteresis
	assign crit_d   = !cmp_ok_q ? crit_q
	                : c_crit.above ? 1'b1
	                : (rdg_int <= crit_rel) ? 1'b0 : crit_q;

	// ****************************************************************
	// status flags
	// ****************************************************************
	logic [7:0] cond_w;     // this conversion's out-of-limit set
	logic [7:0] cond_q;     // latest out-of-limit set, comparator mode
	logic [7:0] status_d;
	logic       status_hot; // an alert-capable flag is set

	assign cond_w = {1'b0, local_hi, 1'b0, c_high.above, c_low.below,
	                 remote_diode_fault_flag, crit_d, 1'b0};
	assign status_hot = |(status_q & temp_alert_pkg::ALERT_SRC);
	// read clears, but a flag set in the same cycle survives
	assign status_d = ((status_rd ? 8'h00 : status_q)
	                  | (cmp_ok_q ? cond_w : 8'h00)) & ~(8'h01 << temp_alert_pkg::ST_BUSY)
	                  | ({7'h00, conv_busy} << temp_alert_pkg::ST_BUSY);

	// comparisons land one cycle after the result is registered
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			status_q <= 8'h00;
			cond_q   <= 8'h00;
			crit_q   <= 1'b0;
		end else begin
			status_q <= status_d;
			crit_q   <= crit_d;
			if (cmp_ok_q) begin
				cond_q <= cond_w;
			end
		end
	end

	// ****************************************************************
	// mask, alert and critical pins
	// ****************************************************************
	logic mask_d;
	logic alert_pull;   // alert line to be pulled low

	// read in interrupt mode with an alert-capable flag set masks; a host write only lands otherwise
	assign mask_d = (status_rd & ~comparator_mode & status_hot) ? 1'b1
	              : mask_wr ? mask_wdata : alert_mask_q;
	// comparator mode follows the live condition, interrupt mode the flags
	assign alert_pull = ~alert_mask_q & (comparator_mode
	                  ? |(cond_q & temp_alert_pkg::ALERT_SRC)
	                  : (status_hot & ~status_rd));

	// pins only ever pull low or release; their data bits sit low in the pin flops
	// below, so every pin of the block leaves a register

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			alert_mask_q         <= 1'b0;
			alert_oe_n_q         <= 1'b1;
			alert_o              <= 1'b0;
			crit_temp_out_o      <= 1'b0;
			crit_temp_out_oe_n_q <= 1'b1;
		end else begin
			alert_mask_q         <= mask_d;
			alert_oe_n_q         <= ~alert_pull;
			alert_o              <= 1'b0;
			crit_temp_out_o      <= 1'b0;
			crit_temp_out_oe_n_q <= ~crit_q;
		end
	end

	// ****************************************************************
	// held settings and standby controls
	// ****************************************************************
	// critical limit stays at reset value until unlocked
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			crit_limit_q <= temp_alert_pkg::CRIT_LIMIT_RST;
			crit_hyst_q  <= temp_alert_pkg::CRIT_HYST_RST;
			lut_hyst_q   <= temp_alert_pkg::LUT_HYST_RST;
			conv_run_q   <= 1'b0;
			pwm_run_q    <= 1'b0;
		end else begin
			if (crit_limit_wr && crit_limit_unlock) begin
				crit_limit_q <= crit_limit_wdata;
			end
			if (crit_hyst_wr) begin
				crit_hyst_q <= hyst_wdata;
			end
			if (lut_hyst_wr) begin
				lut_hyst_q <= hyst_wdata;
			end
			conv_run_q <= ~standby;
			pwm_run_q  <= ~(standby & pwm_off_in_standby);
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_read_hot;
		status_rd && !comparator_mode && status_hot;
	endsequence

	limit_high_a: assert property (cmp_ok_q && c_high.above
		|=> status_q[temp_alert_pkg::ST_RHIGH])
		else $error("remote high flag not set");
	alert_pull_a: assert property (!alert_mask_q && !comparator_mode && status_hot && !status_rd
		|=> !alert_oe_n_q)
		else $error("alert not pulled for set flag");
	pin_release_a: assert property (alert_o == 1'b0 && crit_temp_out_o == 1'b0)
		else $error("open-drain pin drives high");
	crit_pin_a: assert property (crit_q |=> !crit_temp_out_oe_n_q)
		else $error("critical pin not asserted");
	read_mask_a: assert property (s_read_hot |=> alert_mask_q ##1 alert_oe_n_q)
		else $error("status read did not mask and release");
	read_clear_a: assert property (status_rd && !cmp_ok_q |=>
		(status_q & temp_alert_pkg::ALERT_SRC) == 8'h00)
		else $error("status read did not clear flags");
	comp_release_a: assert property ((comparator_mode && !cmp_ok_q &&
		(cond_q & temp_alert_pkg::ALERT_SRC) == 8'h00) [*2] |-> alert_oe_n_q)
		else $error("comparator alert held without cause");
	mask_block_a: assert property (alert_mask_q [*2] |-> alert_oe_n_q)
		else $error("alert pulled while masked");
	crit_lock_a: assert property (!crit_limit_unlock |=> $stable(crit_limit_q))
		else $error("locked critical limit changed");
	standby_a: assert property (standby && conv_done |=> !cmp_ok_q ##1 $stable(cond_q))
		else $error("result taken in standby");
	local_high_a: assert property (cmp_ok_q && local_hi
		|=> status_q[temp_alert_pkg::ST_LHIGH])
		else $error("local high flag not set");
	crit_release_a: assert property (cmp_ok_q && !c_crit.above && rdg_int <= crit_rel
		|=> !crit_q)
		else $error("critical state held below release point");
	conv_stop_a: assert property (standby |=> !conv_run_q)
		else $error("conversions run in standby");
	pwm_stop_a: assert property (standby && pwm_off_in_standby |=> !pwm_run_q)
		else $error("fan output runs in standby");

endmodule

`default_nettype wire

// ### temp_alert_pkg.sv
/*
 * constants for the temperature limit and alert logic: status bit positions,
 * reading formats, reset values of the held settings.
 * assumes readings are left justified 16-bit words in 1/256 degree units.
 */
package temp_alert_pkg;

	// ****************************************************************
	// alert status bit positions
	// ****************************************************************
	localparam int unsigned ST_BUSY     = 7;  // conversion in progress, live
	localparam int unsigned ST_LHIGH    = 6;  // local above local high limit
	localparam int unsigned ST_RHIGH    = 4;  // remote above remote high limit
	localparam int unsigned ST_RLOW     = 3;  // remote below remote low limit
	localparam int unsigned ST_FAULT    = 2;  // remote diode fault
	localparam int unsigned ST_RCRIT    = 1;  // remote above critical limit

	// bits that may pull the alert line; busy and diode fault never do
	localparam logic [7:0]  ALERT_SRC   = 8'h5A;

	// ****************************************************************
	// reading formats
	// ****************************************************************
	localparam logic [15:0] RES_MASK_11 = 16'hFFE0;  // 11-bit, 1/8 degree
	localparam logic [15:0] RES_MASK_13 = 16'hFFF8;  // 13-bit, 1/32 degree
	localparam logic signed [17:0] SIGNED_MAX   = 18'sh0_7FFF;
	localparam logic signed [17:0] SIGNED_MIN   = -18'sh0_8000;
	localparam logic signed [17:0] UNSIGNED_MAX = 18'sh0_FFFF;
	localparam logic signed [17:0] UNSIGNED_MIN = 18'sh0_0000;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [15:0] CRIT_LIMIT_RST = 16'h5500;  // locked critical limit
	localparam logic [7:0]  CRIT_HYST_RST  = 8'h0A;     // critical hysteresis
	localparam logic [7:0]  LUT_HYST_RST   = 8'h04;     // fan table hysteresis

endpackage

// ### limit_cmp_if.sv
/*
 * carrier between the alert logic and one limit comparator.
 * assumes both operands are already extended to 17 signed bits.
 */
`timescale 1ns/1ps
`default_nettype none

interface limit_cmp_if;
	logic signed [16:0] reading;  // extended reading
	logic signed [16:0] limit;    // extended limit
	logic               above;    // reading greater than limit
	logic               below;    // reading less than limit

	modport cmp  (input reading, input limit, output above, output below);
	modport user (output reading, output limit, input above, input below);
endinterface

`default_nettype wire

// ### limit_cmp.sv
/*
 * one signed magnitude comparator of a reading against a limit.
 * assumes operands are extended by the caller per the selected format.
 */
`timescale 1ns/1ps
`default_nettype none

module limit_cmp (
	// comparison carrier
	limit_cmp_if.cmp c
);
	// purely combinational: results are registered by the caller
	assign c.above = (c.reading > c.limit);
	assign c.below = (c.reading < c.limit);
endmodule

`default_nettype wire

// ### alert_host_model.sv
/*
 * host side of the alert line: services an alert as an interrupt.
 * assumes an open-drain alert wire resolved by the bench, pull-up high.
 */
`timescale 1ns/1ps
`default_nettype none

module alert_host_model #(
	parameter int SVC = 8  // cycles spent handling the cause
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rstn,
	// control and pin
	input  wire logic host_en,
	input  wire logic alert_n,
	// host accesses
	output logic      status_rd,
	output logic      mask_wr,
	output logic      mask_wdata
);
	// ****
	// service loop: read status, handle, re-enable
	// ****
	initial begin
		status_rd = 1'b0;
		mask_wr = 1'b0;
		mask_wdata = 1'b0;
		forever begin
			@(posedge mclk);
			#1;
			// only a low wire starts a service
			if (rstn && host_en && alert_n === 1'b0) begin
				status_rd = 1'b1;
				@(posedge mclk);
				#1;
				status_rd = 1'b0;
				repeat (SVC) @(posedge mclk);
				#1;
				mask_wr = 1'b1;
				@(posedge mclk);
				#1;
				mask_wr = 1'b0;
				// let the pin settle before looking again
				repeat (3) @(posedge mclk);
			end
		end
	end
endmodule

`default_nettype wire

// ### tb_top.sv
/*
 * self-checking bench for the alert logic, host model on the far side.
 * assumes outputs settle within three cycles of a conversion strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ****
	// signals
	// ****
	logic mclk, rstn, conv_done, conv_busy, remote_diode_fault_flag, crit_limit_unlock;
	logic crit_limit_wr, crit_hyst_wr, lut_hyst_wr, unsigned_format_sel, filter_en;
	logic comparator_mode, standby, pwm_off_in_standby, status_rd, mask_wr, mask_wdata;
	logic [7:0] local_reading, local_high_limit, remote_offset_hi_byte, remote_offset_lo_byte;
	logic [7:0] hyst_wdata, status_q, local_reading_q, crit_hyst_q, lut_hyst_q;
	logic [15:0] remote_raw, remote_high_limit, remote_low_limit, crit_limit_wdata;
	logic [15:0] remote_reading_q, crit_limit_q, s, r;
	logic alert_mask_q, conv_run_q, pwm_run_q, alert_o, alert_oe_n_q, host_en, cst, ex;
	logic crit_temp_out_o, crit_temp_out_oe_n_q;
	int miscompares, n_compared, i;
	// pins with pull-ups
	wire alert_n = alert_oe_n_q ? 1'b1 : alert_o;
	wire crit_n = crit_temp_out_oe_n_q ? 1'b1 : crit_temp_out_o;
	// expected-value notes
	typedef struct {int c; logic [15:0] v;} note_s;
	note_s q[$];
	event chk_ev;
	string nm [11] = '{"status", "alert", "crit", "mask", "reading", "climit", "chyst",
		"lhyst", "crun", "prun", "local"};
	// offset, raw, corrected per row; mode is {format, filter}
	logic [15:0] tv [6][3] = '{'{16'h0000, 16'h190F, 16'h1900}, '{16'h0000, 16'h190F,
		16'h1908}, '{16'h0100, 16'h1900, 16'h1A00}, '{16'h0100, 16'h7FE0, 16'h7FE0},
		'{16'h0100, 16'hFFE0, 16'hFFE0}, '{16'hFF00, 16'h0000, 16'h0000}};
	logic [1:0] md [6] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2};
	logic [15:0] ct [4] = '{16'h6E00, 16'h6E20, 16'h6A00, 16'h6900};
	logic ce [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

	temp_alert u_dut (.mclk(mclk), .rstn(rstn), .conv_done(conv_done),
		.local_reading(local_reading), .remote_raw(remote_raw), .conv_busy(conv_busy),
		.remote_diode_fault_flag(remote_diode_fault_flag),
		.local_high_limit(local_high_limit), .remote_high_limit(remote_high_limit),
		.remote_low_limit(remote_low_limit), .remote_offset_hi_byte(remote_offset_hi_byte),
		.remote_offset_lo_byte(remote_offset_lo_byte), .crit_limit_unlock(crit_limit_unlock),
		.crit_limit_wr(crit_limit_wr), .crit_limit_wdata(crit_limit_wdata),
		.crit_hyst_wr(crit_hyst_wr), .lut_hyst_wr(lut_hyst_wr), .hyst_wdata(hyst_wdata),
		.unsigned_format_sel(unsigned_format_sel), .filter_en(filter_en),
		.comparator_mode(comparator_mode), .standby(standby),
		.pwm_off_in_standby(pwm_off_in_standby), .status_rd(status_rd), .mask_wr(mask_wr),
		.mask_wdata(mask_wdata), .status_q(status_q), .alert_mask_q(alert_mask_q),
		.remote_reading_q(remote_reading_q), .local_reading_q(local_reading_q),
		.crit_limit_q(crit_limit_q), .crit_hyst_q(crit_hyst_q), .lut_hyst_q(lut_hyst_q),
		.conv_run_q(conv_run_q), .pwm_run_q(pwm_run_q), .alert_o(alert_o),
		.alert_oe_n_q(alert_oe_n_q), .crit_temp_out_o(crit_temp_out_o),
		.crit_temp_out_oe_n_q(crit_temp_out_oe_n_q));
	alert_host_model #(.SVC(8)) u_host (.mclk(mclk), .rstn(rstn), .host_en(host_en),
		.alert_n(alert_n), .status_rd(status_rd), .mask_wr(mask_wr), .mask_wdata(mask_wdata));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// ****
	// helpers
	// ****
	function automatic logic [15:0] seen(input int c);
		case (c)
			0: return {8'h00, status_q};
			1: return {15'h0000, alert_n};
			2: return {15'h0000, crit_n};
			3: return {15'h0000, alert_mask_q};
			4: return remote_reading_q;
			5: return crit_limit_q;
			6: return {8'h00, crit_hyst_q};
			7: return {8'h00, lut_hyst_q};
			8: return {15'h0000, conv_run_q};
			9: return {15'h0000, pwm_run_q};
			default: return {8'h00, local_reading_q};
		endcase
	endfunction
	// fibonacci shift register, taps 16 14 13 11, for random readings
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic note(input int c, input logic [15:0] v);
		q.push_back('{c, v});
		->chk_ev;
	endtask
	task automatic ck(input string n, input logic [15:0] e, input logic [15:0] v);
		n_compared++;
		if (v !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a bounded wait; running out is a mismatch
	task automatic wait_for(input int c, input logic [15:0] v);
		int k;
		for (k = 0; k < 24 && seen(c) !== v; k++) cyc(1);
		if (seen(c) !== v) begin
			ck(nm[c], v, seen(c));
			complete_run();
		end
	endtask
	// three cycles after the strobe every answer has landed
	task automatic conv(input logic [15:0] raw);
		remote_raw = raw;
		conv_done = 1'b1;
		cyc(1);
		conv_done = 1'b0;
		cyc(3);
	endtask
	task automatic pulse(ref logic p);
		p = 1'b1;
		cyc(1);
		p = 1'b0;
		cyc(1);
	endtask

	// ****
	// monitor: drains the notes as they appear
	// ****
	always @(chk_ev) begin
		while (q.size() > 0) begin
			ck(nm[q[0].c], q[0].v, seen(q[0].c));
			void'(q.pop_front());
		end
	end

	// ****
	// main sequence
	// ****
	initial begin
		{conv_done, conv_busy, remote_diode_fault_flag, crit_limit_unlock, crit_limit_wr,
			crit_hyst_wr, lut_hyst_wr, unsigned_format_sel, filter_en, comparator_mode,
			standby, pwm_off_in_standby, host_en, rstn} = '0;
		{remote_offset_hi_byte, remote_offset_lo_byte, hyst_wdata, remote_raw} = '0;
		{local_reading, local_high_limit, crit_limit_wdata} = {8'h14, 8'h32, 16'h6E00};
		{remote_high_limit, remote_low_limit} = {16'h5000, 16'hE700};
		cyc(1);
		note(5, 16'h5500);
		note(6, 16'h000A);
		note(7, 16'h0004);
		note(1, 16'h0001);
		cyc(1);
		rstn = 1'b1;
		// busy is a live copy: a status read must leave it standing
		conv_busy = 1'b1;
		// interrupt mode: host reads, mask set, flags cleared
		host_en = 1'b1;
		conv(16'h5100);
		wait_for(3, 16'h0001);
		note(0, 16'h0080);
		note(1, 16'h0001);
		host_en = 1'b0;
		conv_busy = 1'b0;
		conv(16'h5100);
		note(1, 16'h0001);
		wait_for(3, 16'h0000);
		wait_for(1, 16'h0000);
		// comparator mode follows the condition, flags stay
		comparator_mode = 1'b1;
		conv(16'h1900);
		note(1, 16'h0001);
		note(0, 16'h0010);
		for (i = 0; i < 6; i++) begin
			{unsigned_format_sel, filter_en} = md[i];
			{remote_offset_hi_byte, remote_offset_lo_byte} = tv[i][0];
			conv(tv[i][1]);
			note(4, tv[i][2]);
		end
		{remote_offset_hi_byte, remote_offset_lo_byte, filter_en} = '0;
		{remote_high_limit, remote_low_limit} = {16'hC900, 16'h0000};
		for (i = 0; i < 2; i++) begin
			unsigned_format_sel = i[0];
			conv(16'h4000);
			note(1, {15'h0000, i[0]});
		end
		{remote_high_limit, remote_low_limit, unsigned_format_sel} = {16'h5000, 16'hE700, 1'b0};
		// critical limit lock, then unlock; both hysteresis values
		pulse(crit_limit_wr);
		note(5, 16'h5500);
		crit_limit_unlock = 1'b1;
		pulse(crit_limit_wr);
		note(5, 16'h6E00);
		hyst_wdata = 8'h05;
		pulse(crit_hyst_wr);
		hyst_wdata = 8'h07;
		pulse(lut_hyst_wr);
		note(6, 16'h0005);
		note(7, 16'h0007);
		for (i = 0; i < 4; i++) begin
			conv(ct[i]);
			note(2, {15'h0000, ce[i]});
		end
		// local reading above its own limit pulls the alert as well
		local_reading = 8'h40;
		conv(16'h1900);
		note(10, 16'h0040);
		note(1, 16'h0000);
		local_reading = 8'h14;
		// diode fault never pulls the alert line
		remote_diode_fault_flag = 1'b1;
		conv(16'h1900);
		note(1, 16'h0001);
		remote_diode_fault_flag = 1'b0;
		// random readings against all limits
		s = 16'h42E3;
		cst = 1'b0;
		for (i = 0; i < 8; i++) begin
			s = lfsr(s);
			conv(s);
			r = s & 16'hFFE0;
			if ($signed(r) > $signed(16'h6E00))
				cst = 1'b1;
			else if ($signed(r[15:8]) <= $signed(8'h69))
				cst = 1'b0;
			ex = cst | ($signed(r) > $signed(16'h5000)) | ($signed(r) < $signed(16'hE700));
			note(1, {15'h0000, ~ex});
		end
		// standby stops conversions and optionally the fan output
		{standby, pwm_off_in_standby} = 2'h3;
		cyc(2);
		note(8, 16'h0000);
		note(9, 16'h0000);
		conv(16'h3000);
		note(4, r);
		pwm_off_in_standby = 1'b0;
		cyc(2);
		note(9, 16'h0001);
		standby = 1'b0;
		cyc(2);
		note(8, 16'h0001);
		complete_run();
	end
endmodule

`default_nettype wire
